// [common/ilpc_cfg.svh]
// Offsets, field positions, reset values and timing counts of the interrupt and power block.
`ifndef ILPC_CFG_SVH
`define ILPC_CFG_SVH
// ==========================================================
// Register map
`define ILPC_IMC_ADDR 8'hC8
`define ILPC_IMC_RST 8'h00
`define ILPC_IMC_MASK 8'h70
`define ILPC_RDATA_IDLE 8'h00
// ==========================================================
// Field positions
`define ILPC_LES_BIT 6
`define ILPC_ESB_BIT 5
`define ILPC_GEN_BIT 4
// ==========================================================
// Vector numbers
`define ILPC_VEC_NMI 3'd0
`define ILPC_VEC_COUNT 5
// ==========================================================
// Timing
`define ILPC_CLK_NS 4
`define ILPC_STAB_NS 16384
`define ILPC_STAB_CYC ((`ILPC_STAB_NS + `ILPC_CLK_NS - 1) / `ILPC_CLK_NS)
`endif

// [common/ilpc_pkg.sv]
// Types shared by the interrupt and power block.
`default_nettype none
package ilpc_pkg;
  // Low-power sequencer states.
  typedef enum logic [1:0] {
    ILPC_RUN,
    ILPC_WAIT,
    ILPC_STOP,
    ILPC_STAB
  } ilpc_sleep_t;

  // Core execution mode as seen by the controller.
  typedef enum logic [1:0] {
    ILPC_NORMAL,
    ILPC_INTR,
    ILPC_NMI
  } ilpc_mode_t;
endpackage : ilpc_pkg
`default_nettype wire

// [hw/ilpc_top.sv]
// Interrupt option control, request routing and low-power sequencing.
`timescale 1ns/1ns
`default_nettype none
`include "ilpc_cfg.svh"

// Behaviour
// - Mode register at C8h is write-only; bit operations ignored; bits 7,3..0 unused.
// - Any reset clears the mode register to 00h.
// - Bit 6 set makes source 1 level sensitive; clear selects edge capture.
// - Source 1 in edge mode triggers on a falling edge.
// - Bit 5 picks the edge polarity of source 2, always edge sensitive.
// - Source 2 polarity one means rising edges, zero means falling edges.
// - Bit 4 set enables all interrupts; clear blocks all but the NMI.
// - With global enable clear, NMI is serviced but never wakes the device.
// - With global enable clear, only reset leaves WAIT or STOP.
// - Timer zero and converter done flags go to vector 4, each gated.
// - Reload overflow, compare and edge flags go to vector 3, each gated.
// - Serial done and port C go to vector 2; ports A and B to vector 1.
// - WAIT halts fetch, keeps oscillator, peripherals and storage alive.
// - Waking from WAIT resumes with no stabilisation delay.
// - A reset during WAIT or STOP runs the normal reset procedure.
// - STOP halts oscillator and fetch, keeps storage, waits for interrupt or reset.
// - Waking from STOP inserts an oscillator stabilisation delay first.
// - With a watchdog active, STOP is executed as WAIT.
// - WAIT or STOP is skipped while an enabled request is pending.
// - Slept in main routine: waking interrupt is serviced, then next instruction.
// - Slept in NMI routine: wake resumes, stays in NMI mode, no new service.
// - Slept in interrupt routine, normal wake: routine continues, pending served later.
// - Slept in interrupt routine, NMI wake: NMI runs first, then routine resumes.
// - Waking never changes the selected oscillator source.
module ilpc_top
  import ilpc_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = `ILPC_STAB_CYC
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RESETN,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_BITOP,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       NMI_N,
  input  wire logic       PORTAB_IRQ_N,
  input  wire logic       PORTC_IRQ,
  input  wire logic       TIMER_ZERO_FLAG,
  input  wire logic       TIMER_IRQ_ENABLE,
  input  wire logic       CONV_DONE_FLAG,
  input  wire logic       CONVERTER_IRQ_ENABLE,
  input  wire logic       RELOAD_OVERFLOW_FLAG,
  input  wire logic       RELOAD_OVERFLOW_IRQ_ENABLE,
  input  wire logic       COMPARE_MATCH_FLAG,
  input  wire logic       COMPARE_IRQ_ENABLE,
  input  wire logic       INPUT_EDGE_FLAG,
  input  wire logic       EDGE_IRQ_ENABLE,
  input  wire logic       SERIAL_DONE_FLAG,
  input  wire logic       SERIAL_IRQ_ENABLE,
  input  wire logic       WATCHDOG_ACTIVE,
  input  wire logic       OSC_SELECT_STRAP,
  input  wire logic       CORE_WAIT_EXEC,
  input  wire logic       CORE_STOP_EXEC,
  input  wire logic       CORE_INT_START,
  input  wire logic [2:0] CORE_INT_VECTOR,
  input  wire logic       CORE_RETI,
  output logic      [4:0] IRQ_REQUEST,
  output logic            FETCH_HALT,
  output logic            OSC_RUN,
  output logic            OSC_SELECT,
  output logic            WAKE_RESUME,
  output logic      [1:0] CORE_MODE
);

  // ==========================================================
  // Declarations
  localparam int unsigned CW = $clog2(STAB_CYCLES + 1);
  localparam logic [CW-1:0] STAB_LAST = CW'(STAB_CYCLES - 1);

  logic [7:0]      imc_ff;
  logic [2:0]      sync1_ff;
  logic [2:0]      sync2_ff;
  logic [2:0]      prev_ff;
  logic            nmi_latch_ff;
  logic            src1_latch_ff;
  logic            src2_latch_ff;
  logic            source1_level_select;
  logic            source2_edge_polarity;
  logic            gen;
  logic            nmi_fall;
  logic            src1_fall;
  logic            src2_edge;
  logic            src1_req;
  logic [4:0]      raw_req;
  logic [4:0]      svc_req;
  logic            any_raw;
  logic            any_svc;
  logic            wake;
  ilpc_sleep_t     sleep_ff;
  ilpc_sleep_t     nxt_sleep;
  ilpc_mode_t      mode_ff;
  ilpc_mode_t      saved_ff;
  logic [CW-1:0]   stab_cnt_ff;
  logic            osc_sel_ff;
  logic            strap_done_ff;
  logic            resume_ff;

  // True when a core interrupt start refers to the given vector.
  function automatic logic starts(input logic go, input logic [2:0] v, input logic [2:0] n);
    starts = go && (v == n);
  endfunction : starts

  assign source1_level_select = imc_ff[`ILPC_LES_BIT];
  assign source2_edge_polarity = imc_ff[`ILPC_ESB_BIT];
  assign gen = imc_ff[`ILPC_GEN_BIT];

  // ==========================================================
  // Register port
  // Only the three defined bits are kept, so unused bits always hold zero.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      imc_ff <= `ILPC_IMC_RST;
    end else if (REG_WR && !REG_BITOP && REG_ADDR == `ILPC_IMC_ADDR) begin
      imc_ff <= REG_WDATA & `ILPC_IMC_MASK;
    end
  end

  // The register is write-only, so reads of any address return zero.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      REG_RDATA <= `ILPC_RDATA_IDLE;
    end else begin
      REG_RDATA <= `ILPC_RDATA_IDLE;
    end
  end

  // ==========================================================
  // Pin synchronisers
  // Edge detection looks only at the second stage and its delayed copy.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic pin;
      if (gi == 0) begin : g_n
        assign pin = NMI_N;
      end else if (gi == 1) begin : g_a
        assign pin = PORTAB_IRQ_N;
      end else begin : g_c
        assign pin = PORTC_IRQ;
      end
      // Shifting through reset leaves no false edge at release; hold reset three cycles.
      always_ff @(posedge CORE_CLK) begin
        sync1_ff[gi] <= pin;
        sync2_ff[gi] <= sync1_ff[gi];
        prev_ff[gi]  <= sync2_ff[gi];
      end
    end
  endgenerate

  assign nmi_fall  = prev_ff[0] && !sync2_ff[0];
  assign src1_fall = prev_ff[1] && !sync2_ff[1];
  // Polarity one takes rising edges, zero takes falling edges.
  assign src2_edge = source2_edge_polarity ? (!prev_ff[2] && sync2_ff[2])
                         : (prev_ff[2] && !sync2_ff[2]);

  // ==========================================================
  // Request latches
  // A new edge in the cycle the core starts the routine wins over the clear.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      nmi_latch_ff <= 1'b0;
    end else if (nmi_fall) begin
      nmi_latch_ff <= 1'b1;
    end else if (starts(CORE_INT_START, CORE_INT_VECTOR, `ILPC_VEC_NMI)) begin
      nmi_latch_ff <= 1'b0;
    end
  end

  // Edge latch of source 1 only collects edges while edge mode is chosen.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      src1_latch_ff <= 1'b0;
    end else if (source1_level_select) begin
      src1_latch_ff <= 1'b0;
    end else if (src1_fall) begin
      src1_latch_ff <= 1'b1;
    end else if (starts(CORE_INT_START, CORE_INT_VECTOR, 3'd1)) begin
      src1_latch_ff <= 1'b0;
    end
  end

  // Source 2 is always edge sensitive; only the first edge is stored.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      src2_latch_ff <= 1'b0;
    end else if (src2_edge) begin
      src2_latch_ff <= 1'b1;
    end else if (starts(CORE_INT_START, CORE_INT_VECTOR, 3'd2)) begin
      src2_latch_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Vector routing
  // Level mode of source 1 has no storage; the low line must still be there.
  assign src1_req   = source1_level_select ? !sync2_ff[1] : src1_latch_ff;
  assign raw_req[0] = nmi_latch_ff;
  assign raw_req[1] = src1_req;
  assign raw_req[2] = src2_latch_ff || (SERIAL_DONE_FLAG && SERIAL_IRQ_ENABLE);
  assign raw_req[3] = (RELOAD_OVERFLOW_FLAG && RELOAD_OVERFLOW_IRQ_ENABLE)
                   || (COMPARE_MATCH_FLAG && COMPARE_IRQ_ENABLE)
                   || (INPUT_EDGE_FLAG && EDGE_IRQ_ENABLE);
  assign raw_req[4] = (TIMER_ZERO_FLAG && TIMER_IRQ_ENABLE)
                   || (CONV_DONE_FLAG && CONVERTER_IRQ_ENABLE);

  // Service gating by enable and core mode: NMI mode takes nothing new,
  // interrupt mode takes only the NMI, normal mode takes all.
  always_comb begin
    svc_req    = 5'h00;
    svc_req[0] = raw_req[0] && (mode_ff != ILPC_NMI);
    if (gen && mode_ff == ILPC_NORMAL) begin
      svc_req[4:1] = raw_req[4:1];
    end
  end

  // Requests are withheld while the core sleeps; it services them after resume.
  assign IRQ_REQUEST = (sleep_ff == ILPC_RUN) ? svc_req : 5'h00;
  assign any_svc     = |svc_req;
  assign any_raw     = |raw_req;
  // Any request wakes, but only while the global enable is set.
  assign wake        = gen && any_raw;

  // ==========================================================
  // Core mode tracking
  // One saved level suffices: the NMI can only nest over normal or interrupt mode.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      mode_ff  <= ILPC_NORMAL;
      saved_ff <= ILPC_NORMAL;
    end else if (CORE_INT_START) begin
      saved_ff <= mode_ff;
      mode_ff  <= (CORE_INT_VECTOR == `ILPC_VEC_NMI) ? ILPC_NMI : ILPC_INTR;
    end else if (CORE_RETI) begin
      mode_ff  <= (mode_ff == ILPC_NMI) ? saved_ff : ILPC_NORMAL;
      saved_ff <= ILPC_NORMAL;
    end
  end

  assign CORE_MODE = mode_ff;

  // ==========================================================
  // Low-power sequencer
  always_comb begin
    nxt_sleep = sleep_ff;
    unique case (sleep_ff)
      ILPC_RUN: begin
        if (any_svc) begin
          nxt_sleep = ILPC_RUN;
        end else if (CORE_STOP_EXEC && !WATCHDOG_ACTIVE) begin
          nxt_sleep = ILPC_STOP;
        end else if (CORE_WAIT_EXEC || CORE_STOP_EXEC) begin
          nxt_sleep = ILPC_WAIT;
        end
      end
      ILPC_WAIT: begin
        if (wake) begin
          nxt_sleep = ILPC_RUN;
        end
      end
      ILPC_STOP: begin
        if (wake) begin
          nxt_sleep = ILPC_STAB;
        end
      end
      ILPC_STAB: begin
        if (stab_cnt_ff == STAB_LAST) begin
          nxt_sleep = ILPC_RUN;
        end
      end
    endcase
  end

  // Reset from any sleep state drops straight back to run.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      sleep_ff <= ILPC_RUN;
    end else begin
      sleep_ff <= nxt_sleep;
    end
  end

  // Stabilisation counter runs only during the restart after STOP.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      stab_cnt_ff <= '0;
    end else if (sleep_ff == ILPC_STAB) begin
      stab_cnt_ff <= stab_cnt_ff + CW'(1);
    end else begin
      stab_cnt_ff <= '0;
    end
  end

  // One-cycle pulse on the first cycle back in run after a wake.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      resume_ff <= 1'b0;
    end else begin
      resume_ff <= (sleep_ff != ILPC_RUN) && (nxt_sleep == ILPC_RUN);
    end
  end

  assign WAKE_RESUME = resume_ff;
  assign FETCH_HALT  = (sleep_ff != ILPC_RUN);
  // The oscillator stays on in WAIT so peripherals keep counting.
  assign OSC_RUN     = (sleep_ff != ILPC_STOP);

  // ==========================================================
  // Oscillator selection
  // Caught once after reset release; wake paths never touch it.
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      strap_done_ff <= 1'b0;
      osc_sel_ff    <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      osc_sel_ff    <= OSC_SELECT_STRAP;
    end
  end

  assign OSC_SELECT = osc_sel_ff;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_stop_entry;
    sleep_ff == ILPC_RUN && CORE_STOP_EXEC && !WATCHDOG_ACTIVE && !any_svc;
  endsequence
  sequence s_stop_wake;
    sleep_ff == ILPC_STOP && wake;
  endsequence
  property p_imc_write;
    REG_WR && !REG_BITOP && REG_ADDR == `ILPC_IMC_ADDR
      |=> imc_ff == ($past(REG_WDATA) & `ILPC_IMC_MASK);
  endproperty
  a_imc_write: assert property (p_imc_write) else $error("mode write not taken");
  property p_bitop_ignored;
    REG_WR && REG_BITOP |=> $stable(imc_ff);
  endproperty
  a_bitop_ignored: assert property (p_bitop_ignored) else $error("bit op changed mode");
  property p_read_zero;
    REG_RD |=> REG_RDATA == 8'h00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("write-only read not zero");
  property p_skip_pending;
    sleep_ff == ILPC_RUN && any_svc |=> sleep_ff == ILPC_RUN;
  endproperty
  a_skip_pending: assert property (p_skip_pending) else $error("slept with pending");
  property p_stop_as_wait;
    sleep_ff == ILPC_RUN && CORE_STOP_EXEC && WATCHDOG_ACTIVE && !any_svc
      |=> sleep_ff == ILPC_WAIT && OSC_RUN;
  endproperty
  a_stop_as_wait: assert property (p_stop_as_wait) else $error("STOP not run as WAIT");
  // The resume pulse marks the very first run cycle, beside the dropped halt.
  property p_wait_fast;
    sleep_ff == ILPC_WAIT && wake |=> !FETCH_HALT && WAKE_RESUME;
  endproperty
  a_wait_fast: assert property (p_wait_fast) else $error("WAIT exit delayed");
  property p_stop_delay;
    s_stop_wake |=> FETCH_HALT [*8];
  endproperty
  a_stop_delay: assert property (p_stop_delay) else $error("STOP exit too early");
  property p_stop_osc;
    s_stop_entry |=> !OSC_RUN && FETCH_HALT;
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("STOP kept oscillator");
  property p_no_wake_gen_low;
    (sleep_ff == ILPC_WAIT || sleep_ff == ILPC_STOP) && !gen |=> $stable(sleep_ff);
  endproperty
  a_no_wake_gen_low: assert property (p_no_wake_gen_low) else $error("woke with enable off");
  property p_nmi_mode_blocks;
    mode_ff == ILPC_NMI |-> IRQ_REQUEST == 5'h00;
  endproperty
  a_nmi_mode_blocks: assert property (p_nmi_mode_blocks) else $error("service in NMI mode");
  property p_gen_masks;
    !gen |-> IRQ_REQUEST[4:1] == 4'h0;
  endproperty
  a_gen_masks: assert property (p_gen_masks) else $error("masked request passed");
  property p_osc_sel_kept;
    strap_done_ff && $past(strap_done_ff) |-> $stable(osc_sel_ff);
  endproperty
  a_osc_sel_kept: assert property (p_osc_sel_kept) else $error("oscillator select moved");
  property p_vec4_route;
    TIMER_ZERO_FLAG && TIMER_IRQ_ENABLE |-> raw_req[4];
  endproperty
  a_vec4_route: assert property (p_vec4_route) else $error("vector 4 not raised");
endmodule : ilpc_top
`default_nettype wire

// [verification/ilpc_core_model.sv]
// Processor core model that starts the routine of the highest-priority serviceable request.
`timescale 1ns/1ns
`default_nettype none
module ilpc_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ack_en,
  input  wire logic [4:0] irq_request,
  input  wire logic       fetch_halt,
  output logic            int_start,
  output logic      [2:0] int_vector
);
  logic       start_ff;
  logic [2:0] vector_ff;

  // ==========================================================
  // Service entry
  // One start per request; the idle cycle after it lets the controller drop what it served.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_ff  <= 1'b0;
      vector_ff <= 3'h0;
    end else begin
      start_ff <= 1'b0;
      if (ack_en && !start_ff && !fetch_halt && (irq_request != 5'h00)) begin
        start_ff <= 1'b1;
        // Scanning downward leaves the lowest vector, the NMI first, as the winner.
        for (int i = 4; i >= 0; i--) begin
          if (irq_request[i]) begin
            vector_ff <= 3'(i);
          end
        end
      end
    end
  end

  // Outputs come straight from the registers.
  assign int_start  = start_ff;
  assign int_vector = vector_ff;
endmodule : ilpc_core_model
`default_nettype wire

// [verification/interrupt_and_low_power_control_tb.sv]
// Self-checking bench for the interrupt and low-power controller.
`timescale 1ns/1ns
`default_nettype none
`include "ilpc_cfg.svh"
module interrupt_and_low_power_control_tb;
  localparam int STAB = 12;
  // Vector fed by each flag: timer, converter, three reload timer flags, serial.
  localparam int VEC [6] = '{4, 4, 3, 3, 3, 2};
  logic       core_clk, resetn, reg_wr, reg_bitop, reg_rd, nmi_n, portab_n, portc;
  logic       wd, strap, wait_x, stop_x, reti, ack_en, int_start;
  logic       fetch_halt, osc_run, osc_sel, wake;
  logic [1:0] mode;
  logic [2:0] int_vec;
  logic [4:0] irq;
  logic [5:0] flg, en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, st, irq8;
  int         errors, comparisons;

  // Status byte: mode, halt, oscillator run, oscillator select, resume pulse.
  assign st   = {2'd0, mode, fetch_halt, osc_run, osc_sel, wake};
  assign irq8 = {3'd0, irq};

  ilpc_top #(.STAB_CYCLES(STAB)) i_dut (
    .CORE_CLK(core_clk), .RESETN(resetn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_BITOP(reg_bitop), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .NMI_N(nmi_n), .PORTAB_IRQ_N(portab_n), .PORTC_IRQ(portc),
    .TIMER_ZERO_FLAG(flg[0]), .TIMER_IRQ_ENABLE(en[0]),
    .CONV_DONE_FLAG(flg[1]), .CONVERTER_IRQ_ENABLE(en[1]),
    .RELOAD_OVERFLOW_FLAG(flg[2]), .RELOAD_OVERFLOW_IRQ_ENABLE(en[2]),
    .COMPARE_MATCH_FLAG(flg[3]), .COMPARE_IRQ_ENABLE(en[3]),
    .INPUT_EDGE_FLAG(flg[4]), .EDGE_IRQ_ENABLE(en[4]),
    .SERIAL_DONE_FLAG(flg[5]), .SERIAL_IRQ_ENABLE(en[5]),
    .WATCHDOG_ACTIVE(wd), .OSC_SELECT_STRAP(strap), .CORE_WAIT_EXEC(wait_x),
    .CORE_STOP_EXEC(stop_x), .CORE_INT_START(int_start), .CORE_INT_VECTOR(int_vec),
    .CORE_RETI(reti), .IRQ_REQUEST(irq), .FETCH_HALT(fetch_halt), .OSC_RUN(osc_run),
    .OSC_SELECT(osc_sel), .WAKE_RESUME(wake), .CORE_MODE(mode)
  );

  ilpc_core_model i_core (
    .clk(core_clk), .rst_n(resetn), .ack_en(ack_en), .irq_request(irq),
    .fetch_halt(fetch_halt), .int_start(int_start), .int_vector(int_vec)
  );

  // ==========================================================
  // Clock and watchdog on the whole run
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    report_and_stop();
  end

  // ==========================================================
  // Tasks
  task automatic report_and_stop;
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Waits a bounded time for request b, or for the halt to drop when b is 5.
  task automatic wait_for(input int b);
    int n;
    n = 0;
    while ((b < 5) ? (irq[b] !== 1'b1) : (fetch_halt !== 1'b0)) begin
      if (n == 8) begin
        chk(8'(b), 8'hff);
        report_and_stop();
      end
      n++;
      @(posedge core_clk);
      #1;
    end
  endtask : wait_for

  task automatic do_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    #1;
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_bitop <= b;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_bitop <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
  endtask : rd

  // Core executes WAIT (s low) or STOP (s high) for one cycle.
  task automatic sleep(input logic s);
    @(posedge core_clk);
    wait_x <= !s;
    stop_x <= s;
    @(posedge core_clk);
    wait_x <= 1'b0;
    stop_x <= 1'b0;
    #1;
  endtask : sleep

  // The core model takes one request, then the core returns from it only when ret is high.
  task automatic service(input logic ret);
    @(posedge core_clk);
    ack_en <= 1'b1;
    @(posedge core_clk);
    ack_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    reti <= ret;
    @(posedge core_clk);
    reti <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask : service

  task automatic pin(input int which, input logic v);
    @(posedge core_clk);
    if (which == 1) begin
      portab_n <= v;
    end else begin
      portc <= v;
    end
  endtask : pin

  // ==========================================================
  // Main sequence
  initial begin
    {resetn, reg_wr, reg_bitop, reg_rd, portc, wd, wait_x, stop_x, reti, ack_en} = '0;
    {nmi_n, portab_n, strap} = 3'b111;
    {reg_addr, reg_wdata} = '0;
    {flg, en} = '0;
    errors = 0;
    comparisons = 0;
    do_reset();
    chk(st, 8'h06);
    rd(`ILPC_IMC_ADDR);
    chk(reg_rdata, 8'h00);
    @(posedge core_clk);
    {flg, en} <= 12'hfff;
    #1 chk(irq8, 8'h00);
    wr(`ILPC_IMC_ADDR, 8'hff, 1'b1);
    wr(8'hc9, 8'hff, 1'b0);
    chk(irq8, 8'h00);
    rd(8'hc9);
    chk(reg_rdata, 8'h00);
    wr(`ILPC_IMC_ADDR, 8'hff, 1'b0);
    chk(irq8, 8'h1c);
    // Each flag reaches its own vector alone, and only through its own enable.
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      flg <= 6'(1 << i);
      en  <= 6'h3f;
      #1 chk(irq8, 8'(1 << VEC[i]));
      @(posedge core_clk);
      en <= ~flg;
      #1 chk(irq8, 8'h00);
    end
    @(posedge core_clk);
    {flg, en} <= 12'h03f;
    // Source two with rising polarity, then falling polarity.
    pin(2, 1'b1);
    wait_for(2);
    service(1'b0);
    chk(st, 8'h16);
    service(1'b1);
    pin(2, 1'b0);
    repeat (5) @(posedge core_clk);
    #1 chk(irq8, 8'h00);
    wr(`ILPC_IMC_ADDR, 8'h10, 1'b0);
    pin(2, 1'b1);
    repeat (5) @(posedge core_clk);
    #1 chk(irq8, 8'h00);
    pin(2, 1'b0);
    wait_for(2);
    service(1'b1);
    // Source one: the edge is held after the pin returns, the level is not.
    pin(1, 1'b0);
    wait_for(1);
    pin(1, 1'b1);
    repeat (5) @(posedge core_clk);
    #1 chk(irq8, 8'h02);
    service(1'b1);
    chk(irq8, 8'h00);
    wr(`ILPC_IMC_ADDR, 8'h50, 1'b0);
    pin(1, 1'b0);
    wait_for(1);
    pin(1, 1'b1);
    repeat (5) @(posedge core_clk);
    #1 chk(irq8, 8'h00);
    wr(`ILPC_IMC_ADDR, 8'h10, 1'b0);
    // In the NMI routine nothing maskable is serviced until it returns.
    @(posedge core_clk);
    nmi_n <= 1'b0;
    wait_for(0);
    service(1'b0);
    chk(st, 8'h26);
    @(posedge core_clk);
    flg   <= 6'h01;
    nmi_n <= 1'b1;
    #1 chk(irq8, 8'h00);
    service(1'b1);
    chk(irq8, 8'h10);
    // An NMI taken inside an interrupt routine hands back to interrupt mode.
    service(1'b0);
    chk(st, 8'h16);
    @(posedge core_clk);
    nmi_n <= 1'b0;
    wait_for(0);
    service(1'b0);
    chk(st, 8'h26);
    @(posedge core_clk);
    nmi_n <= 1'b1;
    service(1'b1);
    chk(st, 8'h16);
    service(1'b1);
    chk(irq8, 8'h10);
    sleep(1'b0);
    chk(st, 8'h06);
    // WAIT keeps the oscillator and wakes with no delay.
    @(posedge core_clk);
    flg <= 6'h00;
    sleep(1'b0);
    chk(st, 8'h0e);
    repeat (4) @(posedge core_clk);
    flg <= 6'h01;
    @(posedge core_clk);
    #1 chk(st, 8'h07);
    chk(irq8, 8'h10);
    @(posedge core_clk);
    #1 chk(st, 8'h06);
    // STOP halts the oscillator and waits out the stabilisation delay.
    @(posedge core_clk);
    flg <= 6'h00;
    sleep(1'b1);
    chk(st, 8'h0a);
    repeat (6) @(posedge core_clk);
    flg <= 6'h01;
    repeat (STAB) @(posedge core_clk);
    #1 chk(st, 8'h0e);
    wait_for(5);
    chk(st, 8'h07);
    // With a watchdog running STOP becomes WAIT.
    @(posedge core_clk);
    flg <= 6'h00;
    wd  <= 1'b1;
    sleep(1'b1);
    chk(st, 8'h0e);
    @(posedge core_clk);
    flg <= 6'h01;
    @(posedge core_clk);
    #1 chk(st, 8'h07);
    // Interrupts disabled: neither a flag nor the NMI wakes, only reset does.
    @(posedge core_clk);
    flg <= 6'h00;
    wd  <= 1'b0;
    wr(`ILPC_IMC_ADDR, 8'h00, 1'b0);
    sleep(1'b0);
    @(posedge core_clk);
    flg   <= 6'h01;
    nmi_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    #1 chk(st, 8'h0e);
    @(posedge core_clk);
    nmi_n <= 1'b1;
    do_reset();
    chk(st, 8'h06);
    chk(irq8, 8'h00);
    report_and_stop();
  end
endmodule : interrupt_and_low_power_control_tb
`default_nettype wire
